// File: include/scpb_pkg.sv
// shared constants for the serial communication parameter bank
package scpb_pkg;
  localparam logic [15:0] SCPB_OFF_NODE = 16'h0900;
  localparam logic [15:0] SCPB_OFF_BAUD = 16'h0901;
  localparam logic [15:0] SCPB_OFF_FRAME = 16'h0902;
  localparam logic [15:0] SCPB_OFF_FAULT = 16'h0903;
  localparam logic [15:0] SCPB_OFF_TOEN = 16'h0904;
  localparam logic [15:0] SCPB_OFF_TODUR = 16'h0905;
  localparam logic [15:0] SCPB_OFF_COPY = 16'h0906;
  localparam logic [15:0] SCPB_OFF_LOCK = 16'h0907;
  localparam logic [15:0] SCPB_OFF_RESTORE = 16'h0908;
  localparam logic [15:0] SCPB_OFF_PW_ENTRY = 16'h0806;
  localparam logic [15:0] SCPB_OFF_PW_SETUP = 16'h0807;
  localparam logic [15:0] SCPB_RST_NODE = 16'h0001;
  localparam logic [15:0] SCPB_RST_BAUD = 16'h0001;
  localparam logic [15:0] SCPB_RST_FRAME = 16'h000C;
  localparam logic [15:0] SCPB_RST_FAULT = 16'h0003;
  localparam logic [15:0] SCPB_RST_TOEN = 16'h0000;
  localparam logic [15:0] SCPB_RST_TODUR = 16'h0005;
  localparam logic [15:0] SCPB_RST_COPY = 16'h0000;
  localparam logic [15:0] SCPB_RST_LOCK = 16'h0000;
  localparam logic [15:0] SCPB_RST_RESTORE = 16'h0000;
  localparam logic [15:0] SCPB_NODE_MIN = 16'h0001;
  localparam logic [15:0] SCPB_NODE_MAX = 16'h00FE;
  localparam logic [15:0] SCPB_BAUD_MAX = 16'h0005;
  localparam logic [15:0] SCPB_FRAME_MIN = 16'h0001;
  localparam logic [15:0] SCPB_FRAME_ASCII_MAX = 16'h000B;
  localparam logic [15:0] SCPB_FRAME_MAX = 16'h0011;
  localparam logic [15:0] SCPB_FAULT_MAX = 16'h0003;
  localparam logic [15:0] SCPB_TODUR_MIN = 16'h0001;
  localparam logic [15:0] SCPB_TODUR_MAX = 16'h03E8;
  localparam logic [15:0] SCPB_RESTORE_LOCK = 16'h0001;
  localparam logic [15:0] SCPB_RESTORE_CLR_PRG = 16'h0006;
  localparam logic [15:0] SCPB_RESTORE_DEF50 = 16'h0009;
  localparam logic [15:0] SCPB_RESTORE_DEF60 = 16'h000A;
  localparam logic [3:0] SCPB_CHAR_BITS_ASCII = 4'hA;
  localparam logic [3:0] SCPB_CHAR_BITS_RTU = 4'hB;
  localparam int SCPB_CLK_HZ = 40000000;
  localparam int SCPB_TICK_MS = 100;
  localparam int SCPB_TICK_CYC = SCPB_CLK_HZ / 1000 * SCPB_TICK_MS;
  // fault action codes
  localparam logic [1:0] SCPB_ACT_WARN_RUN = 2'h0;
  localparam logic [1:0] SCPB_ACT_WARN_RAMP = 2'h1;
  localparam logic [1:0] SCPB_ACT_WARN_COAST = 2'h2;
  localparam logic [1:0] SCPB_ACT_SILENT = 2'h3;
  // user program engine state
  typedef enum logic [1:0] {SCPB_PRG_DISABLED, SCPB_PRG_STOPPED, SCPB_PRG_RUNNING} scpb_prg_e;
endpackage : scpb_pkg

// File: verilog/scpb_bank.sv
// serial communication parameter bank with link timeout watchdog
`timescale 1ns/1ps
`default_nettype none

module scpb_bank
  import scpb_pkg::*;
#(
  parameter int TICK_CYC = SCPB_TICK_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic wr_from_keypad,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_hit,
  output logic wr_accept,
  output logic wr_reject,
  output logic comm_fail,
  input wire logic frame_valid,
  input wire logic copy_to_drive_req,
  input wire logic copy_to_keypad_req,
  output logic copy_grant,
  output logic copy_refused_error,
  input wire logic [1:0] prg_state,
  input wire logic power_cycle,
  output logic [15:0] own_address,
  output logic [2:0] baud_code,
  output logic rtu_mode,
  output logic [3:0] char_bits,
  output logic timeout_fault,
  output logic fault_warn,
  output logic fault_ramp_stop,
  output logic fault_coast_stop,
  output logic pend_clear_prg,
  output logic pend_def50,
  output logic pend_def60,
  output logic restore_refused
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] node_address;
  logic [15:0] baud_select;
  logic [15:0] framing_select;
  logic [15:0] comm_fault_action;
  logic [15:0] timeout_enable;
  logic [15:0] timeout_duration;
  logic [15:0] copy_enable;
  logic [15:0] global_lock;
  logic [15:0] restore_command;
  logic [2:0] pend_code;

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // ----------------------------------------
  // write qualification
  // ----------------------------------------
  wire logic hit_node = wr_addr == SCPB_OFF_NODE;
  wire logic hit_baud = wr_addr == SCPB_OFF_BAUD;
  wire logic hit_frame = wr_addr == SCPB_OFF_FRAME;
  wire logic hit_fault = wr_addr == SCPB_OFF_FAULT;
  wire logic hit_toen = wr_addr == SCPB_OFF_TOEN;
  wire logic hit_todur = wr_addr == SCPB_OFF_TODUR;
  wire logic hit_copy = wr_addr == SCPB_OFF_COPY;
  wire logic hit_lock = wr_addr == SCPB_OFF_LOCK;
  wire logic hit_rest = wr_addr == SCPB_OFF_RESTORE;
  wire logic hit_any = hit_node | hit_baud | hit_frame | hit_fault | hit_toen
                     | hit_todur | hit_copy | hit_lock | hit_rest;
  wire logic value_ok = (hit_node & in_range(wr_data, SCPB_NODE_MIN, SCPB_NODE_MAX))
                      | (hit_baud & (wr_data <= SCPB_BAUD_MAX))
                      | (hit_frame & in_range(wr_data, SCPB_FRAME_MIN, SCPB_FRAME_MAX))
                      | (hit_fault & (wr_data <= SCPB_FAULT_MAX))
                      | (hit_toen & (wr_data <= 16'h0001))
                      | (hit_todur & in_range(wr_data, SCPB_TODUR_MIN, SCPB_TODUR_MAX))
                      | (hit_copy & (wr_data <= 16'h0001))
                      | (hit_lock & (wr_data <= 16'h0001))
                      | hit_rest;
  // lock still lets lock itself be cleared, else only a power_cycle or reset could undo it
  wire logic lock_blocks = (global_lock[0] & ~hit_lock);
  wire logic restore_blocks = (restore_command == SCPB_RESTORE_LOCK) & ~hit_rest;
  wire logic copy_serial = hit_copy & ~wr_from_keypad;
  wire logic prg_busy = prg_state != 2'(SCPB_PRG_DISABLED);
  wire logic rest_action = hit_rest & ((wr_data == SCPB_RESTORE_CLR_PRG)
                         | (wr_data == SCPB_RESTORE_DEF50) | (wr_data == SCPB_RESTORE_DEF60));
  wire logic rest_refuse = rest_action & prg_busy;
  wire logic ok_write = hit_any & value_ok & ~lock_blocks & ~restore_blocks
                      & ~copy_serial & ~rest_refuse;
  wire logic do_write = wr_en & ok_write;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n || power_cycle) begin
      node_address <= SCPB_RST_NODE;
      baud_select <= SCPB_RST_BAUD;
      framing_select <= SCPB_RST_FRAME;
      comm_fault_action <= SCPB_RST_FAULT;
      timeout_enable <= SCPB_RST_TOEN;
      timeout_duration <= SCPB_RST_TODUR;
      copy_enable <= SCPB_RST_COPY;
      global_lock <= SCPB_RST_LOCK;
      restore_command <= SCPB_RST_RESTORE;
    end else if (do_write) begin
      if (hit_node) node_address <= wr_data;
      if (hit_baud) baud_select <= wr_data;
      if (hit_frame) framing_select <= wr_data;
      if (hit_fault) comm_fault_action <= wr_data;
      if (hit_toen) timeout_enable <= wr_data;
      if (hit_todur) timeout_duration <= wr_data;
      if (hit_copy) copy_enable <= wr_data;
      if (hit_lock) global_lock <= wr_data;
      if (hit_rest) restore_command <= wr_data;
    end
  end

  // ----------------------------------------
  // deferred restore actions
  // ----------------------------------------
  // pending codes survive into power_cycle and fire for one cycle after it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pend_code <= 3'h0;
    end else if (power_cycle) begin
      pend_code <= 3'h0;
    end else if (do_write && hit_rest) begin
      pend_code <= {wr_data == SCPB_RESTORE_DEF60, wr_data == SCPB_RESTORE_DEF50,
                    wr_data == SCPB_RESTORE_CLR_PRG};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pend_clear_prg <= 1'b0;
      pend_def50 <= 1'b0;
      pend_def60 <= 1'b0;
    end else begin
      pend_clear_prg <= power_cycle & pend_code[0];
      pend_def50 <= power_cycle & pend_code[1];
      pend_def60 <= power_cycle & pend_code[2];
    end
  end

  // ----------------------------------------
  // write answers and copy control
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_accept <= 1'b0;
      wr_reject <= 1'b0;
      comm_fail <= 1'b0;
      restore_refused <= 1'b0;
      copy_grant <= 1'b0;
      copy_refused_error <= 1'b0;
    end else begin
      wr_accept <= do_write;
      wr_reject <= wr_en & ~ok_write;
      comm_fail <= wr_en & copy_serial;
      restore_refused <= wr_en & rest_refuse;
      copy_grant <= copy_to_keypad_req | (copy_to_drive_req & copy_enable[0]);
      copy_refused_error <= copy_to_drive_req & ~copy_to_keypad_req & ~copy_enable[0];
    end
  end

  // ----------------------------------------
  // timeout watchdog
  // ----------------------------------------
  logic [$clog2(TICK_CYC)-1:0] tick_cnt;
  logic [15:0] tenths;
  logic tick;
  assign tick = tick_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1);
  wire logic to_armed = timeout_enable[0];
  wire logic expired = to_armed & (tenths > timeout_duration);

  always_ff @(posedge core_clk) begin
    if (!reset_n || !to_armed || frame_valid) begin
      tick_cnt <= '0;
      tenths <= 16'h0000;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (tick && !expired) tenths <= tenths + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      timeout_fault <= 1'b0;
    end else begin
      timeout_fault <= expired & ~frame_valid;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  wire logic [1:0] act = comm_fault_action[1:0];
  assign fault_warn = timeout_fault & (act != SCPB_ACT_SILENT);
  assign fault_ramp_stop = timeout_fault & (act == SCPB_ACT_WARN_RAMP);
  assign fault_coast_stop = timeout_fault & (act == SCPB_ACT_WARN_COAST);
  assign own_address = node_address;
  assign baud_code = baud_select[2:0];
  assign rtu_mode = framing_select > SCPB_FRAME_ASCII_MAX;
  assign char_bits = rtu_mode ? SCPB_CHAR_BITS_RTU : SCPB_CHAR_BITS_ASCII;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_data <= 16'h0000;
      rd_hit <= 1'b0;
    end else begin
      rd_hit <= rd_addr[15:4] == SCPB_OFF_NODE[15:4] && rd_addr[3:0] <= 4'h8;
      unique case (rd_addr)
        SCPB_OFF_NODE: rd_data <= node_address;
        SCPB_OFF_BAUD: rd_data <= baud_select;
        SCPB_OFF_FRAME: rd_data <= framing_select;
        SCPB_OFF_FAULT: rd_data <= comm_fault_action;
        SCPB_OFF_TOEN: rd_data <= timeout_enable;
        SCPB_OFF_TODUR: rd_data <= timeout_duration;
        SCPB_OFF_COPY: rd_data <= copy_enable;
        SCPB_OFF_LOCK: rd_data <= global_lock;
        SCPB_OFF_RESTORE: rd_data <= restore_command;
        default: rd_data <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  node_range_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    in_range(node_address, SCPB_NODE_MIN, SCPB_NODE_MAX))
    else $error("node address out of range");
  baud_range_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    baud_select <= SCPB_BAUD_MAX)
    else $error("baud code out of range");
  frame_mode_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rtu_mode == (framing_select >= 16'h000C))
    else $error("mode decode wrong");
  char_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    char_bits == (rtu_mode ? 4'hB : 4'hA))
    else $error("character length wrong");
  fault_coast_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    fault_coast_stop |-> comm_fault_action == 16'h0002)
    else $error("coast without code 2");
  timeout_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !timeout_enable[0] |=> !timeout_fault)
    else $error("timeout while disabled");
  frame_restart_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    frame_valid |=> tenths == 16'h0000)
    else $error("frame did not restart timer");
  copy_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    copy_to_drive_req && !copy_to_keypad_req && !copy_enable[0]
    |=> copy_refused_error && !copy_grant)
    else $error("copy into drive not refused");
  serial_copy_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_en && hit_copy && !wr_from_keypad && !power_cycle
    |=> comm_fail && $stable(copy_enable))
    else $error("serial copy write not rejected");
  lock_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    global_lock[0] && wr_en && !hit_lock && !power_cycle
    |=> $stable(node_address) && $stable(baud_select))
    else $error("locked parameter changed");
  restore_ro_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    restore_command == 16'h0001 && !hit_rest && !power_cycle
    |=> $stable(node_address) && $stable(framing_select))
    else $error("read-only parameter changed");
  restore_busy_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_en && rest_action && prg_busy && !power_cycle |=> restore_refused && !pend_clear_prg)
    else $error("restore taken while program busy");
  pend_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    pend_def60 |-> $past(power_cycle))
    else $error("default reset before power cycle");
  copy_pwr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    power_cycle |=> copy_enable == 16'h0000)
    else $error("copy enable survived power cycle");
  wr_answer_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_en |=> wr_accept != wr_reject)
    else $error("write answered twice or not at all");
  rest_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_en && rest_refuse && !power_cycle |=> $stable(restore_command))
    else $error("refused restore was stored");
  keypad_copy_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    copy_to_keypad_req |=> copy_grant && !copy_refused_error)
    else $error("copy to keypad not granted");
  copy_source_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(copy_enable) |-> $past(power_cycle) || $past(wr_from_keypad))
    else $error("copy enable changed from the link");
  fault_silent_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    comm_fault_action == 16'h0003 |-> !fault_warn && !fault_ramp_stop && !fault_coast_stop)
    else $error("silent action still signalled");
  fault_ramp_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    fault_ramp_stop |-> comm_fault_action == 16'h0001 && fault_warn)
    else $error("ramp stop without code 1");
  to_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !to_armed |=> tenths == 16'h0000)
    else $error("timer ran while disabled");
  power_reload_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    power_cycle |=> restore_command == SCPB_RST_RESTORE && node_address == SCPB_RST_NODE)
    else $error("power cycle did not reload defaults");
  pend_quiet_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !power_cycle |=> !pend_clear_prg && !pend_def50 && !pend_def60)
    else $error("restore action without power cycle");

  // ----------------------------------------
  // step-wise checks
  // ----------------------------------------
  // a taken code is only armed; the action waits for the next power_cycle
  sequence rest_taken_s;
    wr_en && ok_write && rest_action && !power_cycle;
  endsequence
  sequence rest_armed_s;
    pend_code != 3'h0;
  endsequence
  sequence link_quiet_s;
    expired && !frame_valid;
  endsequence
  to_fire_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    link_quiet_s |=> timeout_fault)
    else $error("expired timer raised no fault");
  rest_pend_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rest_taken_s |=> rest_armed_s)
    else $error("restore code not held");
  rest_fire_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rest_armed_s ##0 power_cycle |=> pend_clear_prg || pend_def50 || pend_def60)
    else $error("armed restore did not fire");

endmodule : scpb_bank
`default_nettype wire

// File: testbench/scpb_master_model.sv
// bus master model: register writes, reads and frames toward the bank
`timescale 1ns/1ps
`default_nettype none
module scpb_master_model (
  input wire logic core_clk,
  output logic wr_en,
  output logic wr_from_keypad,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data,
  output logic [15:0] rd_addr,
  output logic rd_req,
  output logic frame_valid
);
  initial begin
    wr_en = 1'h0;
    wr_from_keypad = 1'h0;
    wr_addr = 16'h0000;
    wr_data = 16'h0000;
    rd_addr = 16'h0000;
    rd_req = 1'h0;
    frame_valid = 1'h0;
  end
  // one master, one drive: the address is unique by construction
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic kp);
    repeat ($urandom % 3) @(posedge core_clk);
    @(posedge core_clk);
    wr_en <= 1'h1;
    wr_addr <= a;
    wr_data <= d;
    wr_from_keypad <= kp;
    @(posedge core_clk);
    wr_en <= 1'h0;
    // released lines must not keep the last value
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    rd_addr <= a;
    rd_req <= 1'h1;
    @(posedge core_clk);
    rd_req <= 1'h0;
    rd_addr <= ~a;
  endtask : rd
  // a whole frame of 10 or 11 bit characters, seen here as one pulse
  task automatic frame();
    @(posedge core_clk);
    frame_valid <= 1'h1;
    @(posedge core_clk);
    frame_valid <= 1'h0;
  endtask : frame
endmodule : scpb_master_model
`default_nettype wire

// File: testbench/test_scpb_bank.sv
// self-checking testbench for the parameter bank
`timescale 1ns/1ps
`default_nettype none
module test_scpb_bank import scpb_pkg::*;;
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [2:0] tbp;
  logic [1:0] prg;
  wire logic wr_en, wr_from_keypad, rd_req, frame_valid;
  wire logic [15:0] wr_addr, wr_data, rd_addr;
  logic [15:0] rd_data, own_address, n;
  logic rd_hit, wr_accept, wr_reject, comm_fail, copy_grant, copy_refused_error, rtu_mode;
  logic timeout_fault, fault_warn, fault_ramp_stop, fault_coast_stop, restore_refused;
  logic pend_clear_prg, pend_def50, pend_def60, rd_q = 1'h0, e_w;
  logic [2:0] baud_code;
  logic [3:0] char_bits;
  logic exp_wr[$];
  logic [16:0] exp_rd[$];
  int failures = 0, comparisons = 0, i, waited;
  logic [15:0] rst [9] = '{SCPB_RST_NODE, SCPB_RST_BAUD, SCPB_RST_FRAME, SCPB_RST_FAULT,
    SCPB_RST_TOEN, SCPB_RST_TODUR, SCPB_RST_COPY, SCPB_RST_LOCK, SCPB_RST_RESTORE};
  logic [15:0] rcode [3] = '{SCPB_RESTORE_CLR_PRG, SCPB_RESTORE_DEF50, SCPB_RESTORE_DEF60};
  logic [2:0] fexp [4] = '{3'h1, 3'h3, 3'h5, 3'h0};
  wire logic [7:0] ev = {timeout_fault, pend_def60, pend_def50, pend_clear_prg,
    restore_refused, copy_refused_error, copy_grant, comm_fail};

  always #12.5 core_clk = ~core_clk;

  scpb_master_model m (.core_clk, .wr_en, .wr_from_keypad, .wr_addr, .wr_data, .rd_addr,
    .rd_req, .frame_valid);
  // tick shortened so a tenth of a second is four cycles
  scpb_bank #(.TICK_CYC(4)) dut (.core_clk, .reset_n, .wr_en, .wr_from_keypad, .wr_addr,
    .wr_data, .rd_addr, .rd_data, .rd_hit, .wr_accept, .wr_reject, .comm_fail, .frame_valid,
    .copy_to_drive_req(tbp[0]), .copy_to_keypad_req(tbp[1]), .copy_grant, .copy_refused_error,
    .prg_state(prg), .power_cycle(tbp[2]), .own_address, .baud_code, .rtu_mode, .char_bits,
    .timeout_fault, .fault_warn, .fault_ramp_stop, .fault_coast_stop, .pend_clear_prg,
    .pend_def50, .pend_def60, .restore_refused);

  // ---------------------------------------------
  // checking helpers
  // ---------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [15:0] a, input logic [15:0] d, input logic kp, input logic ok);
    exp_wr.push_back(ok);
    m.wr(a, d, kp);
  endtask : w
  task automatic r(input logic [15:0] a, input logic [16:0] e);
    exp_rd.push_back(e);
    m.rd(a);
  endtask : r
  task automatic pulse(input int b);
    @(posedge core_clk);
    tbp[b] <= 1'h1;
    @(posedge core_clk);
    tbp[b] <= 1'h0;
  endtask : pulse
  // bounded wait; running out of cycles ends the run
  task automatic wait_ev(input int b, input logic v);
    for (waited = 1; waited <= 60; waited++) begin
      @(posedge core_clk);
      if (ev[b] === v) break;
    end
    chk({16'h0, ev[b]}, {16'h0, v});
    if (waited > 60) report_and_stop();
  endtask : wait_ev

  // oldest note is matched against each answer as it shows
  always @(posedge core_clk) begin
    rd_q <= rd_req;
    if (wr_accept === 1'h1 || wr_reject === 1'h1) begin
      e_w = exp_wr.pop_front();
      chk({15'h0, wr_accept, wr_reject}, {15'h0, e_w, ~e_w});
    end
    if (rd_q) begin
      chk({rd_hit, rd_data}, exp_rd.pop_front());
    end
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    tbp = 3'h0;
    prg = 2'h0;
    void'($urandom(85296));
    repeat (6) @(posedge core_clk);
    reset_n <= 1'h1;
    for (i = 0; i < 9; i++) r(SCPB_OFF_NODE + 16'(i), {1'h1, rst[i]});
    r(16'h0909, 17'h0);
    w(SCPB_OFF_NODE, 16'h0000, 1'h0, 1'h0);
    w(SCPB_OFF_NODE, 16'h00FF, 1'h0, 1'h0);
    for (i = 0; i < 4; i++) begin
      n = 16'h0001 + 16'($urandom % 254);
      w(SCPB_OFF_NODE, n, 1'h0, 1'h1);
      r(SCPB_OFF_NODE, {1'h1, n});
    end
    w(SCPB_OFF_NODE, 16'h00FE, 1'h0, 1'h1);
    @(negedge core_clk);
    chk({1'h0, own_address}, 17'h00FE);
    for (i = 0; i < 7; i++) begin
      w(SCPB_OFF_BAUD, 16'(i), 1'h0, i < 6);
      @(negedge core_clk);
      if (i < 6) chk({14'h0, baud_code}, 17'(i));
    end
    for (i = 0; i < 19; i++) begin
      w(SCPB_OFF_FRAME, 16'(i), 1'h0, i >= 1 && i <= 17);
      @(negedge core_clk);
      if (i >= 1 && i <= 17) chk({12'h0, rtu_mode, char_bits},
        {12'h0, i > 11, (i > 11) ? 4'hB : 4'hA});
    end
    w(SCPB_OFF_TODUR, 16'h0000, 1'h0, 1'h0);
    w(SCPB_OFF_TODUR, 16'h03E9, 1'h0, 1'h0);
    w(SCPB_OFF_TODUR, 16'h0001, 1'h0, 1'h1);
    for (i = 0; i < 4; i++) begin
      w(SCPB_OFF_FAULT, 16'(i), 1'h0, 1'h1);
      w(SCPB_OFF_TOEN, 16'h0001, 1'h0, 1'h1);
      wait_ev(7, 1'h1);
      chk({16'h0, waited >= 8}, 17'h1);
      chk({14'h0, fault_coast_stop, fault_ramp_stop, fault_warn}, {14'h0, fexp[i]});
      m.frame();
      wait_ev(7, 1'h0);
      w(SCPB_OFF_TOEN, 16'h0000, 1'h0, 1'h1);
    end
    repeat (20) @(posedge core_clk);
    chk({16'h0, timeout_fault}, 17'h0);
    w(SCPB_OFF_FAULT, 16'h0004, 1'h0, 1'h0);
    w(SCPB_OFF_COPY, 16'h0001, 1'h0, 1'h0);
    wait_ev(0, 1'h1);
    pulse(0);
    wait_ev(2, 1'h1);
    pulse(1);
    wait_ev(1, 1'h1);
    w(SCPB_OFF_COPY, 16'h0001, 1'h1, 1'h1);
    pulse(0);
    wait_ev(1, 1'h1);
    w(SCPB_OFF_LOCK, 16'h0001, 1'h1, 1'h1);
    w(SCPB_OFF_NODE, 16'h0005, 1'h0, 1'h0);
    r(SCPB_OFF_NODE, 17'h100FE);
    w(SCPB_OFF_LOCK, 16'h0000, 1'h0, 1'h1);
    @(posedge core_clk);
    prg <= 2'h1 + 2'($urandom % 2);
    w(SCPB_OFF_RESTORE, SCPB_RESTORE_DEF50, 1'h0, 1'h0);
    wait_ev(3, 1'h1);
    prg <= 2'h0;
    w(SCPB_OFF_RESTORE, SCPB_RESTORE_LOCK, 1'h0, 1'h1);
    w(SCPB_OFF_NODE, 16'h0005, 1'h0, 1'h0);
    w(SCPB_OFF_RESTORE, 16'h0000, 1'h0, 1'h1);
    for (i = 0; i < 3; i++) begin
      w(SCPB_OFF_RESTORE, rcode[i], 1'h0, 1'h1);
      pulse(2);
      wait_ev(4 + i, 1'h1);
    end
    r(SCPB_OFF_COPY, 17'h10000);
    r(SCPB_OFF_NODE, 17'h10001);
    repeat (4) @(posedge core_clk);
    chk(17'(exp_wr.size() + exp_rd.size()), 17'h0);
    report_and_stop();
  end
endmodule : test_scpb_bank
`default_nettype wire
